// [verilog/dacx_regs.svh]
// Purpose: constants of the doubleword add/count/extract datapath
// Assumes: 32-bit instruction word, 64-bit operands
// Notes:   definitions only
`ifndef DACX_REGS_SVH
`define DACX_REGS_SVH

`define DACX_MAJOR_LSB      26
`define DACX_MAJOR_S        6'h16
`define DACX_ADDU_FUNC      9'h150
`define DACX_CLO_MINOR      10'h12C
`define DACX_CLZ_MINOR      10'h16C
`define DACX_SX_POOL        6'h3C
`define DACX_EXT_FUNC       6'h2C
`define DACX_MSBD_LSB       11
`define DACX_LSB_LSB        6
`define DACX_RT_LSB         21
`define DACX_REL_EXTRACT    2'h2
`define DACX_REL_NEWEST     2'h3
`define DACX_RESULT_RST     64'h0000000000000000

`endif

// [verilog/dacx_pkg.sv]
// Purpose: types of the doubleword add/count/extract datapath
// Assumes: none
// Notes:   constants live in dacx_regs.svh
package dacx_pkg;
    typedef logic [63:0] dacx_word_t;
    typedef logic [31:0] dacx_insn_t;
    typedef logic [1:0]  dacx_rel_t;
    typedef enum logic [4:0] {
        DACX_OP_NONE = 5'h01,
        DACX_OP_ADD  = 5'h02,
        DACX_OP_CLO  = 5'h04,
        DACX_OP_CLZ  = 5'h08,
        DACX_OP_EXT  = 5'h10
    } dacx_op_e;
endpackage

// [verilog/dacx_decode.sv]
// Purpose: instruction decoder for the doubleword datapath
// Assumes: purely combinational, same clock as the caller
// Notes:   unknown encodings decode to none
`timescale 1ns/1ns
`default_nettype none
`include "dacx_regs.svh"
module dacx_decode
    import dacx_pkg::*;
(
    input  wire dacx_pkg::dacx_insn_t insn,
    output var  dacx_pkg::dacx_op_e   op
);
    always_comb begin
        op = DACX_OP_NONE;
        if (insn[31:`DACX_MAJOR_LSB] == `DACX_MAJOR_S) begin
            if (insn[10:0] == {2'h0, `DACX_ADDU_FUNC}) begin
                op = DACX_OP_ADD;                        // [RULE3]
            end else if (insn[5:0] == `DACX_SX_POOL && insn[15:6] == `DACX_CLO_MINOR) begin
                op = DACX_OP_CLO;                        // [RULE5]
            end else if (insn[5:0] == `DACX_SX_POOL && insn[15:6] == `DACX_CLZ_MINOR) begin
                op = DACX_OP_CLZ;
            end else if (insn[5:0] == `DACX_EXT_FUNC) begin
                op = DACX_OP_EXT;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/dacx_core.sv]
// Purpose: 64-bit add, leading count and field extract datapath
// Assumes: operands already read from the register file
// Notes:   one registered stage, result valid one cycle after issue
//
// Contract
// (RULE1) add wraps modulo two to the 64
// (RULE2) add never traps on overflow
// (RULE3) add decoded by major and function code
// (RULE4) count leading ones, all ones gives 64
// (RULE5) leading-ones decoded by major, minor, pool
// (RULE6) count leading zeros, all zeros gives 64
// (RULE7) newest release traps nonzero second field
// (RULE8) software keeps second field equal destination
// (RULE9) extract field right-justified, zero filled
// (RULE10) size-1 in 15..11, position in 10..6
// (RULE11) software keeps position and size legal
// (RULE12) software picks extract variant by shape
// (RULE13) releases before second trap extract
// (RULE14) every encodable index pair well defined
// (RULE15) counts zero-extended to 64 bits
// (RULE16) single pass, no state between instructions
`timescale 1ns/1ns
`default_nettype none
`include "dacx_regs.svh"
module dacx_core
    import dacx_pkg::*;
(
    input  wire logic                 CLOCK,
    input  wire logic                 RST_N,
    input  wire logic                 ISSUE,
    input  wire dacx_pkg::dacx_insn_t INSN,
    input  wire dacx_pkg::dacx_word_t SRC_A,
    input  wire dacx_pkg::dacx_word_t SRC_B,
    input  wire dacx_pkg::dacx_rel_t  RELEASE,
    output var  dacx_pkg::dacx_word_t RESULT,
    output var  logic                 RESULT_VALID,
    output var  logic                 RESERVED_EXC
);
    import dacx_pkg::*;

    dacx_op_e   op;
    dacx_word_t result_nxt;
    logic       exc_nxt;
    dacx_word_t result_r;
    logic       valid_r;
    logic       exc_r;
    logic [4:0] msbd;
    logic [4:0] lsb;

    dacx_decode u_decode (
        .insn (INSN),
        .op   (op)
    );

    // leading ones of the value; zeros are counted on the inverse
    function automatic logic [6:0] lead_ones(input dacx_word_t v);
        logic [6:0] n;
        logic       run;
        n = 7'h00;
        run = 1'b1;
        for (int i = 63; i >= 0; i--) begin
            run = run & v[i];
            n = n + {6'h00, run};
        end
        return n;
    endfunction

    // field width is at most 32 and start below 32, so no index overflows 63
    function automatic dacx_word_t extract(input dacx_word_t v, input logic [4:0] m, input logic [4:0] l);
        dacx_word_t sh;
        dacx_word_t mask;
        sh = v >> l;
        mask = {32'h0, 32'hFFFFFFFF >> (5'h1F - m)};
        return sh & mask;
    endfunction

    assign msbd = INSN[`DACX_MSBD_LSB +: 5];                   // [RULE10]
    assign lsb  = INSN[`DACX_LSB_LSB +: 5];                    // [RULE10]

    always_comb begin
        result_nxt = `DACX_RESULT_RST;
        exc_nxt = 1'b0;
        case (op)
            DACX_OP_ADD: begin
                result_nxt = SRC_A + SRC_B;                     // [RULE1] [RULE2]
            end
            DACX_OP_CLO: begin
                result_nxt = {57'h0, lead_ones(SRC_A)};         // [RULE4] [RULE15]
                exc_nxt = (RELEASE == `DACX_REL_NEWEST) && (INSN[`DACX_RT_LSB +: 5] != 5'h00); // [RULE7]
            end
            DACX_OP_CLZ: begin
                result_nxt = {57'h0, lead_ones(~SRC_A)};        // [RULE6] [RULE15]
                exc_nxt = (RELEASE == `DACX_REL_NEWEST) && (INSN[`DACX_RT_LSB +: 5] != 5'h00); // [RULE7]
            end
            DACX_OP_EXT: begin
                result_nxt = extract(SRC_A, msbd, lsb);         // [RULE9] [RULE14]
                exc_nxt = (RELEASE < `DACX_REL_EXTRACT);        // [RULE13]
            end
            DACX_OP_NONE: begin
                exc_nxt = 1'b1;
            end
            default: begin
                exc_nxt = 1'b1;
            end
        endcase
        if (exc_nxt) begin
            result_nxt = `DACX_RESULT_RST;
        end
    end

    // result is rebuilt on every issue, nothing carried over
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            result_r <= `DACX_RESULT_RST;
        end else begin
            result_r <= ISSUE ? result_nxt : `DACX_RESULT_RST;  // [RULE16]
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            valid_r <= 1'b0;
            exc_r   <= 1'b0;
        end else begin
            valid_r <= ISSUE & ~exc_nxt;                        // [RULE16]
            exc_r   <= ISSUE & exc_nxt;
        end
    end

    assign RESULT       = result_r;
    assign RESULT_VALID = valid_r;
    assign RESERVED_EXC = exc_r;

    AST_ADD_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE1]
        ISSUE && op == DACX_OP_ADD |=> RESULT == $past(SRC_A) + $past(SRC_B))
        else $error("add result wrong");
    AST_ADD_NO_TRAP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE2]
        ISSUE && op == DACX_OP_ADD |=> RESULT_VALID && !RESERVED_EXC)
        else $error("add trapped");
    AST_CLO_ALL: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
        ISSUE && op == DACX_OP_CLO && SRC_A == 64'hFFFFFFFFFFFFFFFF && RELEASE != `DACX_REL_NEWEST
        |=> RESULT == 64'h40)
        else $error("all ones not 64");
    AST_CLZ_ALL: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE6]
        ISSUE && op == DACX_OP_CLZ && SRC_A == 64'h0 && INSN[25:21] == 5'h00 |=> RESULT == 64'h40)
        else $error("all zeros not 64");
    AST_CLZ_TOP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE6]
        ISSUE && op == DACX_OP_CLZ && SRC_A[63] && INSN[25:21] == 5'h00 |=> RESULT == 64'h0)
        else $error("leading zero count wrong");
    AST_CNT_TRAP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE7]
        ISSUE && (op == DACX_OP_CLO || op == DACX_OP_CLZ) && RELEASE == `DACX_REL_NEWEST
        && INSN[25:21] != 5'h00 |=> RESERVED_EXC && !RESULT_VALID)
        else $error("count field trap missing");
    AST_CNT_RANGE: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE15]
        ISSUE && (op == DACX_OP_CLO || op == DACX_OP_CLZ) |=> RESULT <= 64'h40)
        else $error("count out of range");
    AST_EXT_FIELD: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
        ISSUE && op == DACX_OP_EXT && RELEASE >= `DACX_REL_EXTRACT && msbd == 5'h07
        |=> RESULT == ($past(SRC_A >> lsb) & 64'h00000000000000FF))
        else $error("extract wrong");
    AST_EXT_OLD: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
        ISSUE && op == DACX_OP_EXT && RELEASE < `DACX_REL_EXTRACT |=> RESERVED_EXC)
        else $error("old release extract not trapped");
    AST_EXT_HIGH: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
        ISSUE && op == DACX_OP_EXT |=> RESULT[63:32] == 32'h0)
        else $error("extract high bits set");
    AST_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE16]
        !ISSUE |=> !RESULT_VALID && !RESERVED_EXC && RESULT == 64'h0)
        else $error("output without issue");
    // every issue is answered by exactly one of the two pulses
    AST_ONE_ANSWER: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE16]
        ISSUE |=> RESULT_VALID != RESERVED_EXC)
        else $error("issue not answered once");
    AST_CLO_TOP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
        ISSUE && op == DACX_OP_CLO && !SRC_A[63] && INSN[25:21] == 5'h00 |=> RESULT == 64'h0)
        else $error("leading one count wrong");
    AST_UNKNOWN_TRAP: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE3]
        ISSUE && op == DACX_OP_NONE |=> RESERVED_EXC && RESULT == 64'h0)
        else $error("unknown encoding not trapped");
    AST_EXC_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
        RESERVED_EXC |-> RESULT == 64'h0)
        else $error("trap with nonzero result");

    COV_ADD: cover property (@(posedge CLOCK) disable iff (!RST_N) ISSUE && op == DACX_OP_ADD);
    COV_CLO: cover property (@(posedge CLOCK) disable iff (!RST_N) ISSUE && op == DACX_OP_CLO);
    COV_CLZ: cover property (@(posedge CLOCK) disable iff (!RST_N) ISSUE && op == DACX_OP_CLZ);
    COV_EXT: cover property (@(posedge CLOCK) disable iff (!RST_N) ISSUE && op == DACX_OP_EXT);
    COV_EXC: cover property (@(posedge CLOCK) disable iff (!RST_N) RESERVED_EXC);
endmodule
`default_nettype wire

// [test/dacx_enc_model.sv]
// Purpose: instruction encoder standing for the decode stage
// Assumes: field values already limited to five bits
// Notes:   kind 4 and up gives an unknown major code
`timescale 1ns/1ns
`default_nettype none
module dacx_enc_model (
    input  wire logic [2:0]           kind,
    input  wire logic [4:0]           rt,
    input  wire logic [4:0]           fa,
    input  wire logic [4:0]           fb,
    output var  dacx_pkg::dacx_insn_t insn
);
    import dacx_pkg::*;
    // five-bit fields keep position and size legal for the base form
    always_comb begin
        case (kind)
            3'h0: insn = {6'h16, rt, 5'h00, fa, 2'h0, 9'h150};
            3'h1: insn = {6'h16, rt, 5'h00, 10'h12C, 6'h3C};
            3'h2: insn = {6'h16, rt, 5'h00, 10'h16C, 6'h3C};
            3'h3: insn = {6'h16, rt, 5'h00, fa, fb, 6'h2C};
            default: insn = {6'h15, rt, 5'h00, fa, fb, 6'h2C};
        endcase
    end
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench of the doubleword datapath
// Assumes: result one cycle after issue
// Notes:   reference model recomputes every result
`timescale 1ns/1ns
`default_nettype none
`define CMP(nm, e, s) begin n_compared++; if ((e) !== (s)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb;
    import dacx_pkg::*;
    logic        CLOCK;
    logic        RST_N;
    logic        ISSUE;
    logic [2:0]  kind;
    logic [4:0]  rt;
    logic [4:0]  fa;
    logic [4:0]  fb;
    dacx_insn_t  INSN;
    dacx_word_t  SRC_A;
    dacx_word_t  SRC_B;
    dacx_word_t  RESULT;
    dacx_rel_t   RELEASE;
    logic        RESULT_VALID;
    logic        RESERVED_EXC;
    logic [64:0] exp_q;
    logic        exp_v;
    logic [31:0] seed;
    int          error_cnt;
    int          n_compared;
    dacx_enc_model u_enc (.kind(kind), .rt(rt), .fa(fa), .fb(fb), .insn(INSN));
    dacx_core u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .ISSUE(ISSUE), .INSN(INSN), .SRC_A(SRC_A),
        .SRC_B(SRC_B), .RELEASE(RELEASE), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
        .RESERVED_EXC(RESERVED_EXC));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    // returns {trap, result}
    function automatic logic [64:0] ref_op(input logic [31:0] i, input logic [63:0] a, b, input logic [1:0] rl);
        int          n;
        logic [63:0] r;
        r = '0;
        n = 0;
        if (i[31:26] != 6'h16) return {1'b1, 64'h0};
        if (i[10:0] == 11'h150) return {1'b0, a + b};
        if (i[5:0] == 6'h3C && (i[15:6] == 10'h12C || i[15:6] == 10'h16C)) begin
            if (rl == 2'h3 && i[25:21] != 5'h00) return {1'b1, 64'h0};
            while (n < 64 && a[63 - n] == !i[12]) n++;
            return {1'b0, 64'(n)};
        end
        if (i[5:0] == 6'h2C && rl >= 2'h2) begin
            for (n = 0; n <= i[15:11]; n++) r[n] = a[i[10:6] + n];
            return {1'b0, r};
        end
        return {1'b1, 64'h0};
    endfunction
    task automatic step(input logic iss, input logic [2:0] k, input logic [63:0] a, b,
                        input logic [1:0] rl, input logic [14:0] f);
        @(posedge CLOCK);
        ISSUE <= iss;
        kind <= k;
        SRC_A <= a;
        SRC_B <= b;
        RELEASE <= rl;
        {rt, fa, fb} <= f;
        @(negedge CLOCK);
        `CMP("result", (exp_v && !exp_q[64]) ? exp_q[63:0] : 64'h0, RESULT)
        `CMP("valid", exp_v && !exp_q[64], RESULT_VALID)
        `CMP("exc", exp_v && exp_q[64], RESERVED_EXC)
        exp_v = iss;
        exp_q = ref_op(INSN, SRC_A, SRC_B, RELEASE);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    initial begin
        repeat (5000) @(posedge CLOCK);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        {RST_N, ISSUE, kind, rt, fa, fb, SRC_A, SRC_B, RELEASE, exp_v, exp_q} = '0;
        seed = 32'h9560;
        repeat (4) @(posedge CLOCK);
        RST_N <= 1'b1;
        step(1, 0, '1, 64'h1, 0, 0);
        step(1, 1, '1, 0, 3, 0);
        step(1, 2, 0, 0, 3, 15'h0400);
        step(1, 2, 0, 0, 2, 15'h0400);
        step(1, 3, '1, 0, 2, 15'h03FF);
        step(1, 3, '1, 0, 1, 15'h03FF);
        step(1, 4, '1, 0, 3, 0);
        step(0, 0, 0, 0, 0, 0);
        $display("directed test done");
        repeat (3000) begin
            seed = lfsr(seed);
            step(seed[0] | seed[1], (seed[4:2] > 3'h4) ? 3'h3 : seed[4:2],
                 seed[6] ? ~({2{seed}} >> seed[12:7]) : {2{seed}} >> seed[12:7], {seed, lfsr(seed)},
                 seed[15:14], {seed[21] ? 5'h00 : seed[20:16], seed[26:22], seed[31:27]});
        end
        step(0, 0, 0, 0, 0, 0);
        $display("random test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
